// ### step_exec_pkg.sv
// package of opcodes, timing and constants for the step and bit-branch executor
package step_exec_pkg;
  // opcode encodings
  localparam logic [7:0] OP_INC_A = 8'h04;
  localparam logic [7:0] OP_INC_DIR = 8'h05;
  localparam logic [7:0] OP_INC_IND = 8'h06;
  localparam logic [7:0] OP_INC_REG = 8'h08;
  localparam logic [7:0] OP_DN_A = 8'h14;
  localparam logic [7:0] OP_DN_DIR = 8'h15;
  localparam logic [7:0] OP_DN_IND = 8'h16;
  localparam logic [7:0] OP_DN_REG = 8'h18;
  localparam logic [7:0] OP_DIV = 8'h84;
  localparam logic [7:0] OP_LOOP_REG = 8'hD8;
  localparam logic [7:0] OP_LOOP_DIR = 8'hD5;
  localparam logic [7:0] OP_INC_PTR = 8'hA3;
  localparam logic [7:0] OP_BIT_SET = 8'h20;
  localparam logic [7:0] OP_BIT_CLR = 8'h10;
  localparam logic [7:0] OP_CARRY = 8'h40;
  // masks for forms with register or pointer select bits
  localparam logic [7:0] MASK_REG = 8'hF8;
  localparam logic [7:0] MASK_IND = 8'hFE;
  // instruction lengths
  localparam logic [15:0] LEN_TWO = 16'h0002;
  localparam logic [15:0] LEN_THREE = 16'h0003;
  // divide takes four machine cycles
  localparam int DIV_CYCLES = 4;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // operand target selection
  typedef enum logic [2:0] {
    TGT_NONE = 3'b000,
    TGT_MAIN = 3'b001,
    TGT_REG = 3'b010,
    TGT_DIR = 3'b011,
    TGT_IND = 3'b100
  } target_t;
  // executor states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV = 2'b01,
    ST_DONE = 2'b10
  } exec_state_t;
endpackage : step_exec_pkg

// ### byte_divider.sv
// unsigned eight-bit restoring divider, one quotient bit pair per step
`timescale 1ns/1ps
module byte_divider
  import step_exec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // request
  input wire logic start,
  input wire logic [7:0] dividend,
  input wire logic [7:0] divisor,
  // result
  output logic done,
  output logic [7:0] quotient,
  output logic [7:0] remainder
);
  logic [7:0] quo;
  logic [8:0] rem;
  logic [2:0] step;
  logic busy;
  logic [7:0] next_quo;
  logic [8:0] next_rem;
  logic [2:0] next_step;
  logic next_busy;
  logic next_done;

  // two restoring steps per cycle, four cycles for eight bits
  always_comb begin
    logic [8:0] r;
    logic [7:0] q;
    r = rem;
    q = quo;
    next_step = step;
    next_busy = busy;
    next_done = 1'b0;
    if (start) begin
      r = 9'h000;
      q = dividend;
      next_busy = 1'b1;
      next_step = 3'h0;
    end
    if (start || busy) begin
      for (int k = 0; k < 2; k++) begin
        r = {r[7:0], q[7]};
        q = {q[6:0], 1'b0};
        if (r >= {1'b0, divisor}) begin
          r = r - {1'b0, divisor};
          q[0] = 1'b1;
        end
      end
      next_step = step + 3'h1;
      if (start) next_step = 3'h1;
      if (next_step == 3'(DIV_CYCLES)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
    next_rem = r;
    next_quo = q;
  end

  // state registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      quo <= 8'h00;
      rem <= 9'h000;
      step <= 3'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      quo <= next_quo;
      rem <= next_rem;
      step <= next_step;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign quotient = quo;
  assign remainder = rem[7:0];
endmodule : byte_divider

// ### step_and_bit_branch_exec.sv
// decode and execute of step, count-down, divide, pointer and bit branch opcodes
// Contract
// - subtract-one lowers a byte by one with wrap, flags untouched, for main reg, bank reg, direct and indirect.
// - read-modify-write on an output port takes the old value from the port latch, not the pins.
// - subtract-one opcodes decode as 14h main reg, 18h-1Fh bank reg, 15h direct with address byte.
// - divide puts the unsigned quotient in main reg, remainder in divisor reg, clears carry and excess flag.
// - a zero divisor sets the excess flag and clears carry, results undefined.
// - count-down-branch subtracts one with wrap, no flags, and branches only on a non-zero result.
// - count-down-branch has a bank reg form D8h-DFh and a direct form D5h with address then offset.
// - add-one raises a byte by one with wrap, flags untouched, for main reg, bank reg, direct and indirect.
// - add-one opcodes decode as 04h main reg, 08h-0Fh bank reg, 05h direct, each one machine cycle.
// - indirect add-one is 06h/07h whose low bit selects the window pointer register.
// - pointer increment adds one to the sixteen-bit pointer with carry into the high byte, no flags.
// - branch-on-bit-set advances pc by three and adds the offset if the bit is one, bit kept.
// - branch-set-then-clear branches when the bit is one and clears it in either case, no flags.
// - three-byte bit branches target next pc plus the sign-extended third byte.
// - branch-on-carry is two bytes, advances pc by two and adds the offset when carry is set.
`timescale 1ns/1ps
module step_and_bit_branch_exec
  import step_exec_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // instruction from fetch
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  input wire logic [15:0] pc,
  // operand values from the datapath
  input wire logic [7:0] main_operand_reg,
  input wire logic [7:0] divisor_reg,
  input wire logic [7:0] bank_register_val,
  input wire logic [7:0] window_pointer_reg,
  input wire logic [7:0] indirect_ram_val,
  input wire logic [7:0] direct_ram_val,
  input wire logic direct_is_port,
  input wire logic [7:0] port_latch_val,
  input wire logic addressed_bit,
  input wire logic carry_in,
  input wire logic [7:0] pointer_low_byte,
  input wire logic [7:0] pointer_high_byte,
  // decode results
  output logic instr_ready,
  output logic claimed,
  output logic [2:0] bank_sel,
  // writeback
  output logic wr_valid,
  output target_t wr_target,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic div_wr,
  output logic [7:0] div_quotient,
  output logic [7:0] div_remainder,
  output logic ptr_wr,
  output logic [7:0] next_pointer_low,
  output logic [7:0] next_pointer_high,
  output logic bit_clear,
  output logic flags_wr,
  output logic carry_out,
  output logic arith_excess_flag,
  // program counter
  output logic pc_wr,
  output logic [15:0] pc_out
);
  exec_state_t state;
  exec_state_t next_state;
  logic div_start;
  logic div_done;
  logic div_zero;
  logic next_div_zero;
  logic [7:0] q;
  logic [7:0] r;
  logic [7:0] op_old;
  logic [7:0] op_new;
  target_t tgt;
  logic is_inc;
  logic is_sub;
  logic is_loop;
  logic loop_dir;
  logic [15:0] seq_pc;
  logic [15:0] br_pc;
  logic [7:0] rel;
  logic take;
  logic [15:0] ptr_sum;
  logic next_wr_valid;
  target_t next_wr_target;
  logic [7:0] next_wr_addr;
  logic [7:0] next_wr_data;
  logic next_div_wr;
  logic next_ptr_wr;
  logic next_bit_clear;
  logic next_flags_wr;
  logic next_excess;
  logic next_pc_wr;
  logic [15:0] next_pc_out;
  logic [15:0] next_ptr;

  byte_divider u_div (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .start(div_start),
    .dividend(main_operand_reg),
    .divisor(divisor_reg),
    .done(div_done),
    .quotient(q),
    .remainder(r)
  );

  // operand form decode
  always_comb begin
    tgt = TGT_NONE;
    is_inc = 1'b0;
    is_sub = 1'b0;
    is_loop = 1'b0;
    loop_dir = 1'b0;
    if (opcode == OP_INC_A) begin
      tgt = TGT_MAIN;
      is_inc = 1'b1;
    end else if (opcode == OP_INC_DIR) begin
      tgt = TGT_DIR;
      is_inc = 1'b1;
    end else if ((opcode & MASK_IND) == OP_INC_IND) begin
      tgt = TGT_IND;
      is_inc = 1'b1;
    end else if ((opcode & MASK_REG) == OP_INC_REG) begin
      tgt = TGT_REG;
      is_inc = 1'b1;
    end else if (opcode == OP_DN_A) begin
      tgt = TGT_MAIN;
      is_sub = 1'b1;
    end else if (opcode == OP_DN_DIR) begin
      tgt = TGT_DIR;
      is_sub = 1'b1;
    end else if ((opcode & MASK_IND) == OP_DN_IND) begin
      tgt = TGT_IND;
      is_sub = 1'b1;
    end else if ((opcode & MASK_REG) == OP_DN_REG) begin
      tgt = TGT_REG;
      is_sub = 1'b1;
    end else if ((opcode & MASK_REG) == OP_LOOP_REG) begin
      tgt = TGT_REG;
      is_loop = 1'b1;
    end else if (opcode == OP_LOOP_DIR) begin
      tgt = TGT_DIR;
      is_loop = 1'b1;
      loop_dir = 1'b1;
    end
  end

  // operand fetch; port targets read the output latch
  always_comb begin
    unique case (tgt)
      TGT_MAIN: op_old = main_operand_reg;
      TGT_REG: op_old = bank_register_val;
      TGT_DIR: op_old = direct_is_port ? port_latch_val : direct_ram_val;
      TGT_IND: op_old = indirect_ram_val;
      default: op_old = BYTE_ZERO;
    endcase
    op_new = is_inc ? op_old + BYTE_ONE : op_old - BYTE_ONE;
  end

  always_comb begin
    rel = byte2;
    seq_pc = pc + LEN_TWO;
    if (opcode == OP_BIT_SET || opcode == OP_BIT_CLR || loop_dir) begin
      rel = byte3;
      seq_pc = pc + LEN_THREE;
    end
    br_pc = seq_pc + {{8{rel[7]}}, rel};
    ptr_sum = {pointer_high_byte, pointer_low_byte} + 16'h0001;
  end

  // main execute sequencer
  always_comb begin
    next_state = state;
    next_wr_valid = 1'b0;
    next_wr_target = TGT_NONE;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_div_wr = 1'b0;
    next_ptr_wr = 1'b0;
    next_ptr = {next_pointer_high, next_pointer_low};
    next_bit_clear = 1'b0;
    next_flags_wr = 1'b0;
    next_excess = arith_excess_flag;
    next_pc_wr = 1'b0;
    next_pc_out = pc_out;
    next_div_zero = div_zero;
    div_start = 1'b0;
    take = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (instr_valid) begin
          if (is_inc || is_sub) begin
            next_wr_valid = 1'b1;
            next_wr_target = tgt;
            next_wr_addr = (tgt == TGT_IND) ? window_pointer_reg : byte2;
            next_wr_data = op_new;
          end else if (is_loop) begin
            next_wr_valid = 1'b1;
            next_wr_target = tgt;
            next_wr_addr = byte2;
            next_wr_data = op_new;
            take = (op_new != BYTE_ZERO);
            next_pc_wr = 1'b1;
            next_pc_out = take ? br_pc : seq_pc;
          end else if (opcode == OP_DIV) begin
            div_start = 1'b1;
            next_div_zero = (divisor_reg == BYTE_ZERO);
            next_state = ST_DIV;
          end else if (opcode == OP_INC_PTR) begin
            next_ptr_wr = 1'b1;
            next_ptr = ptr_sum;
          end else if (opcode == OP_BIT_SET || opcode == OP_BIT_CLR) begin
            take = addressed_bit;
            next_pc_wr = 1'b1;
            next_pc_out = take ? br_pc : seq_pc;
            next_bit_clear = (opcode == OP_BIT_CLR);
          end else if (opcode == OP_CARRY) begin
            take = carry_in;
            next_pc_wr = 1'b1;
            next_pc_out = take ? br_pc : seq_pc;
          end
        end
      end
      ST_DIV: begin
        if (div_done) begin
          // quotient and remainder out, carry cleared
          next_div_wr = 1'b1;
          next_flags_wr = 1'b1;
          next_excess = div_zero;
          next_state = ST_DONE;
        end
      end
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // registered outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      wr_valid <= 1'b0;
      wr_target <= TGT_NONE;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      div_wr <= 1'b0;
      ptr_wr <= 1'b0;
      next_pointer_low <= 8'h00;
      next_pointer_high <= 8'h00;
      bit_clear <= 1'b0;
      flags_wr <= 1'b0;
      arith_excess_flag <= 1'b0;
      pc_wr <= 1'b0;
      pc_out <= 16'h0000;
      div_zero <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      wr_valid <= next_wr_valid;
      wr_target <= next_wr_target;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      div_wr <= next_div_wr;
      ptr_wr <= next_ptr_wr;
      next_pointer_low <= next_ptr[7:0];
      next_pointer_high <= next_ptr[15:8];
      bit_clear <= next_bit_clear;
      flags_wr <= next_flags_wr;
      arith_excess_flag <= next_excess;
      pc_wr <= next_pc_wr;
      pc_out <= next_pc_out;
      div_zero <= next_div_zero;
    end
  end

  // handshake and decode visibility
  assign instr_ready = (state == ST_IDLE);
  assign claimed = is_inc || is_sub || is_loop || opcode == OP_DIV || opcode == OP_INC_PTR
    || opcode == OP_BIT_SET || opcode == OP_BIT_CLR || opcode == OP_CARRY;
  assign bank_sel = opcode[2:0];
  assign carry_out = 1'b0;
  assign div_quotient = q;
  assign div_remainder = r;
endmodule : step_and_bit_branch_exec

// ### step_exec_asserts.sv
// port checker for the step and bit-branch executor
`timescale 1ns/1ps
module step_exec_asserts
  import step_exec_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // instruction
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  input wire logic [15:0] pc,
  // operands
  input wire logic [7:0] main_operand_reg,
  input wire logic [7:0] divisor_reg,
  input wire logic addressed_bit,
  input wire logic carry_in,
  input wire logic [7:0] pointer_low_byte,
  input wire logic [7:0] pointer_high_byte,
  // results
  input wire logic instr_ready,
  input wire logic wr_valid,
  input wire target_t wr_target,
  input wire logic [7:0] wr_data,
  input wire logic div_wr,
  input wire logic ptr_wr,
  input wire logic [7:0] next_pointer_low,
  input wire logic [7:0] next_pointer_high,
  input wire logic bit_clear,
  input wire logic flags_wr,
  input wire logic carry_out,
  input wire logic arith_excess_flag,
  input wire logic pc_wr,
  input wire logic [15:0] pc_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // request taken on this edge
  wire logic go = ce && instr_valid && instr_ready;
  // sign extension of an offset byte
  function automatic logic [15:0] sx(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction : sx
  chk_inc_main: assert property (go && opcode == OP_INC_A |=> wr_valid && wr_target == TGT_MAIN
    && wr_data == $past(main_operand_reg) + 8'h01) else $error("add one result wrong");
  chk_div_delay: assert property (go && opcode == OP_DIV |=>
    (!div_wr && !instr_ready) [*4] ##1 (div_wr && flags_wr)) else $error("divide timing wrong");
  chk_div_flags: assert property (go && opcode == OP_DIV |-> ##5 !carry_out
    && arith_excess_flag == ($past(divisor_reg, 5) == 8'h00)) else $error("divide flags wrong");
  chk_flags_div: assert property (flags_wr |-> div_wr) else $error("flag write outside divide");
  chk_ptr_step: assert property (go && opcode == OP_INC_PTR |=> ptr_wr
    && {next_pointer_high, next_pointer_low} == $past({pointer_high_byte, pointer_low_byte}) + 16'h0001)
    else $error("pointer step wrong");
  chk_carry_branch: assert property (go && opcode == OP_CARRY |=> pc_wr
    && pc_out == $past(pc) + 16'h0002 + ($past(carry_in) ? sx($past(byte2)) : 16'h0000)) else $error("carry branch");
  chk_bit_target: assert property (go && opcode == OP_BIT_SET |=> pc_wr && !bit_clear
    && pc_out == $past(pc) + 16'h0003 + ($past(addressed_bit) ? sx($past(byte3)) : 16'h0000)) else $error("bit branch");
  chk_bit_clear: assert property (go && opcode == OP_BIT_CLR |=> bit_clear && pc_wr)
    else $error("bit not cleared");
endmodule : step_exec_asserts

// ### tb_top.sv
// self-checking bench for the step and bit-branch executor
`timescale 1ns/1ps
module tb_top;
  import step_exec_pkg::*;
  logic clk, resetn, ce, instr_valid, direct_is_port, addressed_bit, carry_in;
  logic [7:0] opcode, byte2, byte3, main_operand_reg, divisor_reg, bank_register_val, window_pointer_reg;
  logic [7:0] indirect_ram_val, direct_ram_val, port_latch_val, pointer_low_byte, pointer_high_byte;
  logic [15:0] pc, pc_out;
  logic instr_ready, claimed, wr_valid, div_wr, ptr_wr, bit_clear, flags_wr, carry_out, arith_excess_flag, pc_wr;
  logic [2:0] bank_sel;
  target_t wr_target;
  logic [7:0] wr_addr, wr_data, div_quotient, div_remainder, next_pointer_low, next_pointer_high;
  int n_errors = 0;
  int comparisons = 0;
  logic [7:0] ops [8] = '{OP_INC_A, 8'h0B, OP_INC_DIR, 8'h07, OP_DN_A, 8'h1B, OP_DN_DIR, 8'h17};
  logic [7:0] exp [8] = '{8'h00, 8'h01, 8'h81, 8'h01, 8'hFE, 8'hFF, 8'h7F, 8'hFF};
  target_t tg [4] = '{TGT_MAIN, TGT_REG, TGT_DIR, TGT_IND};
  step_and_bit_branch_exec step_and_bit_branch_exec_i (.*);
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // compare tasks
  task chk(input logic [15:0] got, input logic [15:0] want, input string what);
    comparisons++;
    if (got !== want) begin
      n_errors++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask : chk
  task chk1(input logic got, input logic want, input string what);
    chk({15'h0000, got}, {15'h0000, want}, what);
  endtask : chk1
  // one instruction, taken on the edge after it is driven
  task issue(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3);
    @(posedge clk) #1;
    {opcode, byte2, byte3} = {op, b2, b3};
    instr_valid = 1'b1;
    @(posedge clk) #1;
    instr_valid = 1'b0;
  endtask : issue
  // branch and its pc outcome
  task br(input logic [7:0] op, input logic c, input logic [7:0] b2, input logic [7:0] b3,
          input logic [15:0] tgt, input logic clr);
    {addressed_bit, carry_in} = {c, c};
    issue(op, b2, b3);
    chk1(pc_wr, 1'b1, "pc write");
    chk(pc_out, tgt, "pc target");
    chk1(bit_clear, clr, "bit clear");
    chk1(flags_wr, 1'b0, "flag write");
  endtask : br
  // divide and its four-cycle answer
  task dv(input logic [7:0] a, input logic [7:0] b, input logic [7:0] q, input logic [7:0] r);
    {main_operand_reg, divisor_reg} = {a, b};
    issue(OP_DIV, 8'h00, 8'h00);
    chk1(instr_ready, 1'b0, "busy");
    repeat (4) @(posedge clk);
    #1;
    chk1(div_wr, 1'b1, "divide write");
    chk1(carry_out, 1'b0, "carry");
    chk1(arith_excess_flag, b == 8'h00, "excess flag");
    if (b != 8'h00) chk({div_quotient, div_remainder}, {q, r}, "quotient");
    @(posedge clk) #1;
    chk1(instr_ready, 1'b1, "ready again");
  endtask : dv
  task summarize;
    $display("%0d comparisons, %0d errors", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  // watchdog
  initial begin
    #20000;
    n_errors++;
    summarize;
  end
  // main sequence
  initial begin
    {resetn, instr_valid, addressed_bit, carry_in, opcode, byte2, byte3, divisor_reg} = '0;
    {pointer_low_byte, pointer_high_byte, indirect_ram_val} = '0;
    {main_operand_reg, bank_register_val, window_pointer_reg} = {8'hFF, 8'h00, 8'h30};
    {ce, pc, port_latch_val, direct_ram_val, direct_is_port} = {1'b1, 16'h1000, 8'h80, 8'h13, 1'b1};
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    // all step forms, port operand read from its latch
    for (int i = 0; i < 8; i++) begin
      issue(ops[i], 8'h40, 8'h00);
      chk1(wr_valid, 1'b1, "write pulse");
      chk(16'(wr_target), 16'(tg[i % 4]), "target");
      chk(16'(wr_data), 16'(exp[i]), "step data");
      chk1(flags_wr, 1'b0, "no flags");
      if (i % 4 == 1) chk(16'(bank_sel), 16'h0003, "bank select");
      if (i % 4 > 1) chk(16'(wr_addr), (i % 4 == 2) ? 16'h0040 : 16'h0030, "address");
    end
    // direct operand from ram when the address is no port
    direct_is_port = 1'b0;
    issue(OP_INC_DIR, 8'h40, 8'h00);
    chk(16'(wr_data), 16'h0014, "ram operand");
    direct_is_port = 1'b1;
    issue(8'h00, 8'h00, 8'h00);
    chk({13'h0000, claimed, wr_valid, pc_wr}, 16'h0000, "foreign opcode");
    // enable low freezes all state
    ce = 1'b0;
    issue(OP_INC_A, 8'h00, 8'h00);
    chk1(wr_valid, 1'b0, "frozen by enable");
    ce = 1'b1;
    $display("step tests done");
    {pointer_high_byte, pointer_low_byte} = 16'h12FF;
    issue(OP_INC_PTR, 8'h00, 8'h00);
    chk({next_pointer_high, next_pointer_low}, 16'h1300, "pointer carry");
    {pointer_high_byte, pointer_low_byte} = 16'hFFFF;
    issue(OP_INC_PTR, 8'h00, 8'h00);
    chk({7'h00, ptr_wr, next_pointer_high}, 16'h0100, "pointer wrap");
    $display("pointer tests done");
    br(OP_BIT_SET, 1'b1, 8'h40, 8'h80, 16'h0F83, 1'b0);
    br(OP_BIT_SET, 1'b0, 8'h40, 8'h80, 16'h1003, 1'b0);
    br(OP_BIT_CLR, 1'b1, 8'h40, 8'h10, 16'h1013, 1'b1);
    br(OP_BIT_CLR, 1'b0, 8'h40, 8'h10, 16'h1003, 1'b1);
    br(OP_CARRY, 1'b1, 8'h7F, 8'h00, 16'h1081, 1'b0);
    br(OP_CARRY, 1'b0, 8'h7F, 8'h00, 16'h1002, 1'b0);
    bank_register_val = 8'h01;
    br(8'hD9, 1'b0, 8'h7F, 8'h00, 16'h1002, 1'b0);
    chk(16'(wr_data), 16'h0000, "count to zero");
    bank_register_val = 8'h05;
    br(8'hD9, 1'b0, 8'hFE, 8'h00, 16'h1000, 1'b0);
    chk(16'(wr_data), 16'h0004, "count down");
    br(OP_LOOP_DIR, 1'b0, 8'h40, 8'h05, 16'h1008, 1'b0);
    chk({wr_addr, wr_data}, 16'h407F, "direct count");
    $display("branch tests done");
    dv(8'hFB, 8'h12, 8'h0D, 8'h11);
    dv(8'h20, 8'h00, 8'h00, 8'h00);
    $display("divide tests done");
    summarize;
  end
endmodule : tb_top
bind step_and_bit_branch_exec step_exec_asserts step_exec_asserts_i (.*);
